// ==== core/ddr_odt_zq_pkg.sv ====
// Shared constants and types for the DRAM termination / calibration model and its controller.
// Assumes one clock at 20 MHz shared by both ends and synchronous pins.
package ddr_odt_zq_pkg;
  localparam int CLK_MHZ = 20;
  localparam int CNT_W = 16;

  // Write latency and derived figures, in clock cycles.
  localparam int WL_DEF = 5;
  localparam int SYNC_LAT_SUB = 2;
  localparam int LEAD_SUB = 1;

  // Plain defaults for figures that are not printed, in clock cycles.
  localparam int ASYNC_LAT_DEF = 1;
  localparam int CPDED_DEF = 1;
  localparam int RFC_DEF = 8;
  localparam int XPDLL_DEF = 10;
  localparam int TRP_DEF = 1;
  localparam int TXS_DEF = 12;
  localparam int ZQINIT_DEF = 512;
  localparam int ZQOPER_DEF = 256;
  localparam int ZQCS_NCK = 64;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // Mode register bit value that freezes the DLL in precharge power-down.
  localparam logic DLL_FROZEN_VAL = 1'b0;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_REF = 3'b001,
    CMD_ZQCL = 3'b010,
    CMD_ZQCS = 3'b011,
    CMD_PREA = 3'b100,
    CMD_SRE = 3'b101
  } cmd_t;

  typedef enum logic [1:0] {
    DS_IDLE = 2'b00,
    DS_PD = 2'b01,
    DS_SR = 2'b10
  } dram_state_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b000,
    CS_TRP = 3'b001,
    CS_ZQ = 3'b010,
    CS_PD = 3'b011,
    CS_SR = 3'b100,
    CS_XS = 3'b101
  } ctrl_state_t;
endpackage

// ==== core/ddr_link_if.sv ====
// Command, CKE, ODT and mode-bit link between the controller and the DRAM model.
// Assumes both ends share clk_i; all wires change only after a rising edge.
`timescale 1ns/1ps
interface ddr_link_if;
  import ddr_odt_zq_pkg::*;
  cmd_t cmd;
  logic cke;
  logic odt;
  logic dll_mode;

  modport ctrl (output cmd, output cke, output odt, output dll_mode);
  modport dram (input cmd, input cke, input odt, input dll_mode);
endinterface

// ==== core/dram_odt_zq.sv ====
// DRAM end: termination timing across power-down and the calibration engine.
// Assumes the controller keeps its own sequencing duties on the link.
`timescale 1ns/1ps
module dram_odt_zq #(
  parameter int WL = ddr_odt_zq_pkg::WL_DEF,
  parameter int ASYNC_LAT = ddr_odt_zq_pkg::ASYNC_LAT_DEF,
  parameter int CPDED = ddr_odt_zq_pkg::CPDED_DEF,
  parameter int RFC = ddr_odt_zq_pkg::RFC_DEF,
  parameter int XPDLL = ddr_odt_zq_pkg::XPDLL_DEF,
  parameter int ZQINIT = ddr_odt_zq_pkg::ZQINIT_DEF,
  parameter int ZQOPER = ddr_odt_zq_pkg::ZQOPER_DEF,
  parameter int ZQCS = ddr_odt_zq_pkg::ZQCS_NCK
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  ddr_link_if.dram link,
  output logic rtt_on_o,
  output logic async_mode_o,
  output logic window_o,
  output logic zq_busy_o,
  output logic zq_current_o,
  output logic cal_valid_o,
  output ddr_odt_zq_pkg::dram_state_t state_o
);
  import ddr_odt_zq_pkg::*;

  localparam int SYNC_LAT = WL - SYNC_LAT_SUB;
  localparam int LEAD = WL - LEAD_SUB;
  localparam logic [CNT_W-1:0] CPDED_C = CNT_W'(CPDED);
  localparam logic [CNT_W-1:0] RFC_C = CNT_W'(RFC);
  localparam logic [CNT_W-1:0] XPDLL_C = CNT_W'(XPDLL);
  localparam logic [CNT_W-1:0] ZQINIT_C = CNT_W'(ZQINIT);
  localparam logic [CNT_W-1:0] ZQOPER_C = CNT_W'(ZQOPER);
  localparam logic [CNT_W-1:0] ZQCS_C = CNT_W'(ZQCS);

  logic [SYNC_LAT-1:0] sync_q, sync_d;
  logic [ASYNC_LAT-1:0] async_q, async_d;
  logic rtt_q, rtt_d;
  logic amode_q, amode_d;
  logic cke_q, cke_d;
  dram_state_t st_q, st_d;
  logic [CNT_W-1:0] rfc_q, rfc_d;
  logic [CNT_W-1:0] win_q, win_d;
  logic [CNT_W-1:0] zq_q, zq_d;
  logic first_q, first_d;
  logic valid_q, valid_d;
  logic frozen;
  logic cke_fall;
  logic cke_rise;
  logic [CNT_W-1:0] entry_len;

  assign frozen = (link.dll_mode == DLL_FROZEN_VAL);
  assign cke_fall = cke_q && !link.cke;
  assign cke_rise = !cke_q && link.cke;

  // Termination pipes: the synchronous path carries write latency (additive
  // latency included), the asynchronous one bypasses it.
  always_comb begin
    sync_d = SYNC_LAT'({sync_q, link.odt});
    async_d = ASYNC_LAT'({async_q, link.odt});
    // Inside a window either response is legal, so the mode held from the
    // previous region is kept and its own bounds lie within the merged ones.
    if (amode_q) begin
      rtt_d = async_q[ASYNC_LAT-1];
    end else begin
      rtt_d = sync_q[SYNC_LAT-1];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_q <= '0;
      async_q <= '0;
      rtt_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      async_q <= async_d;
      rtt_q <= rtt_d;
    end
  end

  // Power state, refresh tracking and transition windows. The lead part of a
  // window lies before CKE is seen, so only its tail is visible here; the
  // held mode covers the lead part because the mode only moves afterwards.
  always_comb begin
    cke_d = link.cke;
    st_d = st_q;
    rfc_d = (rfc_q != CNT_ZERO) ? rfc_q - CNT_ONE : CNT_ZERO;
    win_d = (win_q != CNT_ZERO) ? win_q - CNT_ONE : CNT_ZERO;
    amode_d = amode_q;
    if (link.cmd == CMD_REF && st_q == DS_IDLE) begin
      rfc_d = RFC_C;
    end
    // Only the refresh time still left after this edge may stretch the window,
    // so that its last cycle lines up with the refresh end as for the entry delay.
    entry_len = (rfc_d > CPDED_C) ? rfc_d : CPDED_C;
    unique case (st_q)
      DS_IDLE: begin
        if (cke_fall) begin
          st_d = (link.cmd == CMD_SRE) ? DS_SR : DS_PD;
        end
      end
      DS_PD: begin
        if (cke_rise) begin
          st_d = DS_IDLE;
        end
      end
      DS_SR: begin
        if (cke_rise) begin
          st_d = DS_IDLE;
        end
      end
    endcase
    if (frozen && cke_fall && link.cmd != CMD_SRE) begin
      // A window still running is stretched, never cut short.
      if (entry_len > win_q) begin
        win_d = entry_len;
      end
    end
    if (frozen && cke_rise && st_q == DS_PD) begin
      if (XPDLL_C > win_q) begin
        win_d = XPDLL_C;
      end
    end
    if (win_q == CNT_ONE || (win_q == CNT_ZERO && !cke_fall && !cke_rise)) begin
      amode_d = frozen && st_q == DS_PD;
    end
    if (cke_rise) begin
      // Leaving power-down with a running DLL returns straight to sync timing.
      amode_d = amode_q && frozen;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke_q <= 1'b0;
      st_q <= DS_IDLE;
      rfc_q <= CNT_ZERO;
      win_q <= CNT_ZERO;
      amode_q <= 1'b0;
    end else begin
      cke_q <= cke_d;
      st_q <= st_d;
      rfc_q <= rfc_d;
      win_q <= win_d;
      amode_q <= amode_d;
    end
  end

  // Calibration engine. It starts only on an explicit command, so leaving
  // self-refresh never triggers it.
  always_comb begin
    zq_d = zq_q;
    first_d = first_q;
    valid_d = valid_q;
    if (zq_q != CNT_ZERO) begin
      zq_d = zq_q - CNT_ONE;
      if (zq_q == CNT_ONE) begin
        valid_d = 1'b1;
      end
    end else if (st_q == DS_IDLE && link.cke) begin
      if (link.cmd == CMD_ZQCL) begin
        zq_d = first_q ? ZQINIT_C : ZQOPER_C;
        first_d = 1'b0;
      end else if (link.cmd == CMD_ZQCS) begin
        zq_d = ZQCS_C;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zq_q <= CNT_ZERO;
      first_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      zq_q <= zq_d;
      first_q <= first_d;
      valid_q <= valid_d;
    end
  end

  assign rtt_on_o = rtt_q;
  assign async_mode_o = amode_q;
  assign window_o = (win_q != CNT_ZERO);
  assign zq_busy_o = (zq_q != CNT_ZERO);
  // The reference current flows only while the engine counts.
  assign zq_current_o = (zq_q != CNT_ZERO);
  assign cal_valid_o = valid_q;
  assign state_o = st_q;

  // Lead time is not a counter here; kept so its value is tied to WL.
  logic [CNT_W-1:0] lead_unused;
  assign lead_unused = CNT_W'(LEAD);
endmodule

// ==== core/ddr_ctrl_odt_zq.sv ====
// Controller end: power-down, self-refresh, refresh and calibration sequencing.
// Assumes a single DRAM on its own calibration resistor and user requests as levels.
`timescale 1ns/1ps
module ddr_ctrl_odt_zq #(
  parameter int TRP = ddr_odt_zq_pkg::TRP_DEF,
  parameter int TXS = ddr_odt_zq_pkg::TXS_DEF,
  parameter int ZQINIT = ddr_odt_zq_pkg::ZQINIT_DEF,
  parameter int ZQOPER = ddr_odt_zq_pkg::ZQOPER_DEF,
  parameter int ZQCS = ddr_odt_zq_pkg::ZQCS_NCK
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  ddr_link_if.ctrl link,
  input wire logic zqcl_req_i,
  input wire logic zqcs_req_i,
  input wire logic ref_req_i,
  input wire logic pd_req_i,
  input wire logic sr_req_i,
  input wire logic odt_req_i,
  input wire logic dll_mode_i,
  output logic ready_o,
  output logic zq_done_o,
  output ddr_odt_zq_pkg::ctrl_state_t state_o
);
  import ddr_odt_zq_pkg::*;

  localparam logic [CNT_W-1:0] TRP_C = CNT_W'(TRP);
  localparam logic [CNT_W-1:0] TXS_C = CNT_W'(TXS);
  localparam logic [CNT_W-1:0] ZQINIT_C = CNT_W'(ZQINIT);
  localparam logic [CNT_W-1:0] ZQOPER_C = CNT_W'(ZQOPER);
  localparam logic [CNT_W-1:0] ZQCS_C = CNT_W'(ZQCS);

  ctrl_state_t st_q, st_d;
  cmd_t cmd_q, cmd_d;
  logic cke_q, cke_d;
  logic odt_q, odt_d;
  logic dll_q, dll_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic long_q, long_d;
  logic first_q, first_d;
  logic done_q, done_d;

  always_comb begin
    st_d = st_q;
    cmd_d = CMD_NOP;
    cke_d = cke_q;
    odt_d = odt_req_i;
    dll_d = dll_q;
    cnt_d = (cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO;
    long_d = long_q;
    first_d = first_q;
    done_d = 1'b0;
    unique case (st_q)
      CS_IDLE: begin
        dll_d = dll_mode_i;
        cke_d = 1'b1;
        if (zqcl_req_i || zqcs_req_i) begin
          cmd_d = CMD_PREA;
          long_d = zqcl_req_i;
          cnt_d = TRP_C;
          odt_d = 1'b0;
          st_d = CS_TRP;
        end else if (ref_req_i) begin
          cmd_d = CMD_REF;
        end else if (sr_req_i) begin
          cmd_d = CMD_SRE;
          cke_d = 1'b0;
          odt_d = 1'b0;
          st_d = CS_SR;
        end else if (pd_req_i) begin
          cke_d = 1'b0;
          st_d = CS_PD;
        end
      end
      CS_TRP: begin
        odt_d = 1'b0;
        if (cnt_q == CNT_ZERO) begin
          cmd_d = long_q ? CMD_ZQCL : CMD_ZQCS;
          if (long_q) begin
            cnt_d = first_q ? ZQINIT_C : ZQOPER_C;
            first_d = 1'b0;
          end else begin
            cnt_d = ZQCS_C;
          end
          st_d = CS_ZQ;
        end
      end
      CS_ZQ: begin
        // Nothing else is issued until the period ends, which also keeps
        // calibrations on a shared resistor apart.
        odt_d = 1'b0;
        if (cnt_q == CNT_ONE) begin
          done_d = 1'b1;
          st_d = CS_IDLE;
        end
      end
      CS_PD: begin
        if (!pd_req_i) begin
          cke_d = 1'b1;
          st_d = CS_IDLE;
        end
      end
      CS_SR: begin
        odt_d = 1'b0;
        if (!sr_req_i) begin
          cke_d = 1'b1;
          cnt_d = TXS_C;
          st_d = CS_XS;
        end
      end
      CS_XS: begin
        // Calibration requests wait here until the exit delay has passed.
        odt_d = 1'b0;
        if (cnt_q == CNT_ONE) begin
          st_d = CS_IDLE;
        end
      end
      default: begin
        st_d = CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= CS_IDLE;
      cmd_q <= CMD_NOP;
      cke_q <= 1'b0;
      odt_q <= 1'b0;
      dll_q <= DLL_FROZEN_VAL;
      cnt_q <= CNT_ZERO;
      long_q <= 1'b0;
      first_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cmd_q <= cmd_d;
      cke_q <= cke_d;
      odt_q <= odt_d;
      dll_q <= dll_d;
      cnt_q <= cnt_d;
      long_q <= long_d;
      first_q <= first_d;
      done_q <= done_d;
    end
  end

  assign link.cmd = cmd_q;
  assign link.cke = cke_q;
  assign link.odt = odt_q;
  assign link.dll_mode = dll_q;
  assign ready_o = (st_q == CS_IDLE);
  assign zq_done_o = done_q;
  assign state_o = st_q;
endmodule

// ==== tb/ddr_odt_zq_monitor.sv ====
// Checker on the link between the controller and the DRAM end.
// Assumes TRP=1, CPDED=1, RFC=3, XPDLL=3 and the default write latency.
`timescale 1ns/1ps
module ddr_odt_zq_monitor #(
  parameter int ZQINIT = 8,
  parameter int ZQOPER = 6
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input ddr_odt_zq_pkg::cmd_t cmd,
  input wire logic cke,
  input wire logic odt,
  input wire logic dll_mode,
  input wire logic rtt_on_o,
  input wire logic async_mode_o,
  input wire logic window_o,
  input wire logic zq_busy_o,
  input wire logic zq_current_o,
  input wire logic cal_valid_o,
  input ddr_odt_zq_pkg::dram_state_t state_o
);
  import ddr_odt_zq_pkg::*;
  logic take;
  logic first_q;
  logic [15:0] cnt_q;
  logic [15:0] exp_q;
  assign take = (cmd == CMD_ZQCL || cmd == CMD_ZQCS) && cke && !zq_busy_o && state_o == DS_IDLE;
  // The count of busy cycles is held at the falling edge so the period can be judged there.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 16'h0000;
      exp_q <= 16'h0000;
      first_q <= 1'b1;
    end else begin
      cnt_q <= zq_busy_o ? cnt_q + 16'h0001 : 16'h0000;
      if (take) begin
        exp_q <= (cmd == CMD_ZQCS) ? 16'(ZQCS_NCK) : (first_q ? 16'(ZQINIT) : 16'(ZQOPER));
        first_q <= first_q && cmd != CMD_ZQCL;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence zq_take_s;
    take;
  endsequence
  sequence zq_run_s;
    zq_busy_o && zq_current_o;
  endsequence
  busy_quiet_a: assert property (zq_busy_o |-> cmd == CMD_NOP)
    else $error("command issued during calibration");
  busy_pins_a: assert property (zq_busy_o |-> cke && !odt)
    else $error("clock enable low or termination asked during calibration");
  zq_order_a: assert property (zq_take_s |-> $past(cmd, 2) == CMD_PREA)
    else $error("calibration not preceded by precharge all");
  zq_start_a: assert property (zq_take_s |=> zq_run_s)
    else $error("calibration did not start");
  zq_period_a: assert property ($fell(zq_busy_o) |-> cnt_q == exp_q && cal_valid_o && !zq_current_o)
    else $error("calibration period or result transfer wrong");
  rtt_sync_a: assert property ($rose(odt) && !async_mode_o && !window_o |-> !rtt_on_o [*4] ##1 rtt_on_o)
    else $error("synchronous termination latency wrong");
  async_on_a: assert property ($rose(odt) && async_mode_o && !window_o |-> !rtt_on_o [*2] ##1 rtt_on_o)
    else $error("asynchronous turn-on delay wrong");
  async_off_a: assert property ($fell(odt) && async_mode_o && !window_o |-> rtt_on_o [*2] ##1 !rtt_on_o)
    else $error("asynchronous turn-off delay wrong");
  entry_win_a: assert property ($fell(cke) && state_o == DS_IDLE && !dll_mode && cmd != CMD_SRE
    && $past(cmd) != CMD_REF |=> window_o ##1 (!window_o && async_mode_o))
    else $error("power-down entry window wrong");
  entry_ref_a: assert property ($fell(cke) && state_o == DS_IDLE && !dll_mode
    && $past(cmd) == CMD_REF |=> window_o [*2] ##1 (!window_o && async_mode_o))
    else $error("refresh did not stretch the entry window");
  exit_win_a: assert property ($rose(cke) && state_o == DS_PD && !dll_mode |=> window_o [*3] ##1 !window_o)
    else $error("power-down exit window wrong");
endmodule

// ==== tb/tb.sv ====
// Self-checking bench joining the controller and the DRAM end over the link.
// Assumes short calibration and exit counts, set here through parameters.
`timescale 1ns/1ps
module tb;
  import ddr_odt_zq_pkg::*;
  localparam int ZQI = 8;
  localparam int ZQO = 6;
  localparam int XPD = 3;
  localparam int RFC_T = 3;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic zqcl_req_i = 1'b0;
  logic zqcs_req_i = 1'b0;
  logic pd_req_i = 1'b0;
  logic ref_req_i = 1'b0;
  logic sr_req_i = 1'b0;
  logic odt_req_i = 1'b0;
  logic dll_mode_i = 1'b0;
  logic rtt_on_o, async_mode_o, window_o, zq_busy_o, zq_current_o, cal_valid_o;
  logic ready_o, zq_done_o;
  dram_state_t dram_state;
  ctrl_state_t ctrl_state;
  int failures = 0;
  int comparisons = 0;
  int n, k;
  always #25 clk_i = ~clk_i;
  ddr_link_if link_if();
  dram_odt_zq #(.RFC(RFC_T), .XPDLL(XPD), .ZQINIT(ZQI), .ZQOPER(ZQO)) i_dram_odt_zq (
    .clk_i(clk_i), .nrst_i(nrst_i), .link(link_if), .rtt_on_o(rtt_on_o),
    .async_mode_o(async_mode_o), .window_o(window_o), .zq_busy_o(zq_busy_o),
    .zq_current_o(zq_current_o), .cal_valid_o(cal_valid_o), .state_o(dram_state));
  ddr_ctrl_odt_zq #(.TXS(3), .ZQINIT(ZQI), .ZQOPER(ZQO)) i_ddr_ctrl_odt_zq (
    .clk_i(clk_i), .nrst_i(nrst_i), .link(link_if), .zqcl_req_i(zqcl_req_i),
    .zqcs_req_i(zqcs_req_i), .ref_req_i(ref_req_i), .pd_req_i(pd_req_i), .sr_req_i(sr_req_i),
    .odt_req_i(odt_req_i), .dll_mode_i(dll_mode_i), .ready_o(ready_o),
    .zq_done_o(zq_done_o), .state_o(ctrl_state));
  ddr_odt_zq_monitor #(.ZQINIT(ZQI), .ZQOPER(ZQO)) i_ddr_odt_zq_monitor (
    .clk_i(clk_i), .nrst_i(nrst_i), .cmd(link_if.cmd), .cke(link_if.cke), .odt(link_if.odt),
    .dll_mode(link_if.dll_mode), .rtt_on_o(rtt_on_o), .async_mode_o(async_mode_o),
    .window_o(window_o), .zq_busy_o(zq_busy_o), .zq_current_o(zq_current_o),
    .cal_valid_o(cal_valid_o), .state_o(dram_state));
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Outputs are looked at one nanosecond after the edge, once its updates have landed.
  task automatic tick;
    @(posedge clk_i);
    #1;
    n++;
  endtask
  task automatic zq_run(input logic long_cal, input int period);
    @(posedge clk_i);
    if (long_cal) zqcl_req_i <= 1'b1;
    else zqcs_req_i <= 1'b1;
    @(posedge clk_i);
    zqcl_req_i <= 1'b0;
    zqcs_req_i <= 1'b0;
    n = 0;
    do tick; while (zq_done_o !== 1'b1 && n < 200);
    chk_n(n, 2 + period);
    // The DRAM saw the command one cycle after it left, so it finishes one cycle later.
    chk_b(zq_busy_o, 1'b1);
    tick;
    chk_b(zq_busy_o, 1'b0);
    chk_b(cal_valid_o, 1'b1);
    chk_b(zq_current_o, 1'b0);
    $display("calibration test done, period %0d", period);
  endtask
  task automatic odt_lat(input logic v, input int lat);
    @(posedge clk_i);
    odt_req_i <= v;
    n = 0;
    do tick; while (rtt_on_o !== v && n < 20);
    chk_n(n, lat);
    $display("termination test done, latency %0d", lat);
  endtask
  task automatic pd_run(input logic frozen);
    @(posedge clk_i);
    dll_mode_i <= !frozen;
    pd_req_i <= 1'b1;
    n = 0;
    do tick; while (link_if.cke !== 1'b0 && n < 20);
    tick;
    chk_b(window_o, frozen);
    tick;
    chk_b(window_o, 1'b0);
    chk_b(async_mode_o, frozen);
    if (frozen) begin
      odt_lat(1'b1, 3);
      odt_lat(1'b0, 3);
    end
    @(posedge clk_i);
    pd_req_i <= 1'b0;
    n = 0;
    do tick; while (link_if.cke !== 1'b1 && n < 20);
    k = 0;
    repeat (8) begin
      tick;
      if (window_o === 1'b1) k++;
    end
    chk_n(k, frozen ? XPD : 0);
    chk_b(async_mode_o, 1'b0);
    $display("power-down test done, frozen %0d", frozen);
  endtask
  // A refresh taken one cycle before CKE falls leaves its time minus that cycle.
  task automatic ref_pd_run;
    @(posedge clk_i);
    dll_mode_i <= 1'b0;
    ref_req_i <= 1'b1;
    @(posedge clk_i);
    ref_req_i <= 1'b0;
    pd_req_i <= 1'b1;
    n = 0;
    do tick; while (link_if.cke !== 1'b0 && n < 20);
    k = 0;
    repeat (4) begin
      tick;
      if (window_o === 1'b1) k++;
    end
    chk_n(k, RFC_T - 1);
    chk_b(async_mode_o, 1'b1);
    @(posedge clk_i);
    pd_req_i <= 1'b0;
    n = 0;
    do tick; while (link_if.cke !== 1'b1 && n < 20);
    repeat (XPD + 2) tick;
    chk_b(window_o, 1'b0);
    chk_b(async_mode_o, 1'b0);
    $display("refresh power-down test done");
  endtask
  task automatic sr_run;
    @(posedge clk_i);
    sr_req_i <= 1'b1;
    n = 0;
    do tick; while (dram_state !== DS_SR && n < 20);
    chk_b(window_o, 1'b0);
    chk_n(ctrl_state, CS_SR);
    @(posedge clk_i);
    sr_req_i <= 1'b0;
    n = 0;
    k = 0;
    do begin
      tick;
      if (zq_busy_o !== 1'b0) k++;
    end while (ready_o !== 1'b1 && n < 40);
    chk_n(k, 0);
    $display("self-refresh test done");
    zq_run(1'b0, ZQCS_NCK);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk_b(cal_valid_o, 1'b0);
    zq_run(1'b1, ZQI);
    zq_run(1'b1, ZQO);
    zq_run(1'b0, ZQCS_NCK);
    odt_lat(1'b1, WL_DEF);
    odt_lat(1'b0, WL_DEF);
    pd_run(1'b1);
    ref_pd_run;
    pd_run(1'b0);
    sr_run;
    end_of_test;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    end_of_test;
  end
endmodule
